/* File: spi_baud_gen.sv */
// Baud prescaler and power-of-two divider for the master bit clock.
// Assumes run_i is held high for the whole transfer.
`timescale 1ns/100ps
module spi_baud_gen (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] pre_sel_i,
    input  wire logic [2:0] div_sel_i,
    // Half bit period strobe
    output logic            half_tick_o
);
    import spi_baud_pkg::*;

    logic [2:0] pre_cnt_q;
    logic [7:0] div_cnt_q;
    wire        pre_hit;
    wire  [7:0] half_span;
    wire  [7:0] div_last;
    wire        div_hit;

    // The bus clock feeds the prescaler; it wraps after select+1 clocks.
    assign pre_hit   = (pre_cnt_q == pre_sel_i);
    // The divider counts prescaler pulses over half of 2^(select+1).
    assign half_span = 8'h01 << div_sel_i;
    assign div_last  = half_span - 8'h01;
    assign div_hit   = pre_hit && (div_cnt_q == div_last);
    // Each half period toggles the bit clock, so a full bit clock
    // takes prescale times divisor bus clocks.
    assign half_tick_o = run_i && div_hit;

    // Counters hold at zero while idle so each transfer starts clean.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_cnt_q <= 3'h0;
            div_cnt_q <= 8'h00;
        end else if (!run_i) begin
            pre_cnt_q <= 3'h0;
            div_cnt_q <= 8'h00;
        end else begin
            pre_cnt_q <= pre_hit ? 3'h0 : pre_cnt_q + 3'h1;
            if (pre_hit) begin
                div_cnt_q <= div_hit ? 8'h00 : div_cnt_q + 8'h01;
            end
        end
    end

endmodule : spi_baud_gen

/* File: spi_baud_pkg.sv */
// Package with register offsets, field positions and reset values.
// Assumes one 8-bit register port with a 3-bit register address.
package spi_baud_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [2:0] OFS_CONTROL_ONE = 3'h0;
    localparam logic [2:0] OFS_CONTROL_TWO = 3'h1;
    localparam logic [2:0] OFS_BAUD_CONFIG = 3'h2;
    localparam logic [2:0] OFS_SERIAL_STAT = 3'h3;
    localparam logic [2:0] OFS_DATA_REG    = 3'h4;
    localparam logic [2:0] OFS_EVENT_STAT  = 3'h5;
    localparam logic [2:0] OFS_EVENT_MASK  = 3'h6;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_RX_FAULT_IRQ_EN = 7;
    localparam int BIT_SYSTEM_ENABLE   = 6;
    localparam int BIT_TX_IRQ_ENABLE   = 5;
    localparam int BIT_MASTER_SELECT   = 4;
    localparam int BIT_SEL_OUT_ENABLE  = 1;
    localparam int BIT_FAULT_ENABLE    = 4;
    localparam int PRE_SEL_HI          = 6;
    localparam int PRE_SEL_LO          = 4;
    localparam int DIV_SEL_HI          = 2;
    localparam int DIV_SEL_LO          = 0;
    localparam int BIT_RX_FULL         = 7;
    localparam int BIT_TX_EMPTY        = 5;
    localparam int BIT_MODE_FAULT      = 4;
    localparam int EVT_DONE            = 0;
    localparam int EVT_FAULT           = 1;
    localparam int EVT_TX_ROOM         = 2;

    // ****************************************************************
    // Reset values and counts
    // ****************************************************************
    localparam logic [7:0] RST_CONTROL_ONE = 8'h00;
    localparam logic [7:0] RST_CONTROL_TWO = 8'h00;
    localparam logic [7:0] RST_BAUD_CONFIG = 8'h00;
    localparam logic [2:0] RST_EVENTS      = 3'h0;
    localparam logic [4:0] LAST_EDGE       = 5'h0F;
    localparam int         SYNC_WIDTH      = 2;

endpackage : spi_baud_pkg

/* File: spi_baud_top.sv */
// Serial unit top: registers, status flags, interrupts and a master
// shifter clocked by the baud generator.
// Assumes a single-cycle register port on clk_i and asynchronous
// serial pins; slave-side shifting is not built here.
//
// Overview of operation
// - Prescaler divides bus clock by prescale field plus one, bits 6:4.
// - Bus clock drives the prescaler, which drives the divider.
// - Divider field in bits 2:0 selects divide by 2 to 256.
// - Divider output is the master serial bit clock.
// - Baud register is readable and writable at any time.
// - Unused status bits read zero; status writes are ignored.
// - Receive-full flag, bit 7, sets when a transfer completes.
// - Receive-full clears after status read with flag set, then data read.
// - Transmit-empty flag, bit 5, sets when a byte enters the shifter.
// - Transmit-empty clears on armed data write; unarmed writes ignored.
// - Transmit interrupt while transmit-empty and its enable are set.
// - Idle unit loads a written byte, sets transmit-empty in two cycles.
// - At shift end a queued byte reloads; otherwise nothing moves.
// - Mode-fault flag, bit 4, sets when master sees select low.
// - Select pin is a fault input only for master, fault on, output off.
// - Mode-fault clears after status read seeing it, then control-one write.
// - Receive/fault interrupt when either flag and its enable are set.
// - Disable: halt, empty buffers, clear receive-full, set transmit-empty.
`timescale 1ns/100ps
module spi_baud_top (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Register port
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Serial pins
    input  wire logic       miso_i,
    input  wire logic       ss_n_i,
    output logic            sclk_o,
    output logic            mosi_o,
    // Interrupts
    output logic            tx_irq_o,
    output logic            rx_fault_irq_o,
    output logic            event_irq_o
);
    import spi_baud_pkg::*;

    // All checks below run on the bus clock and rest during reset.
    default clocking main_cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ****************************************************************
    // State and storage
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_type;

    shift_state_type state_q;
    shift_state_type state_d;
    logic [7:0] control_one_q;
    logic [7:0] control_two_q;
    logic [7:0] baud_config_q;
    logic [7:0] tx_buf_q;
    logic [7:0] rx_buf_q;
    logic [7:0] shift_q;
    logic [4:0] edge_cnt_q;
    logic       sample_q;
    logic       sclk_q;
    logic       tx_empty_flag_q;
    logic       rx_full_flag_q;
    logic       mode_fault_flag_q;
    logic       arm_rx_q;
    logic       arm_tx_q;
    logic       arm_fault_q;
    logic [2:0] event_stat_q;
    logic [2:0] event_mask_q;
    logic [7:0] rdata_q;
    logic       tx_irq_q;
    logic       rx_fault_irq_q;
    logic       event_irq_q;
    logic [SYNC_WIDTH-1:0] pin_sync;
    logic       half_tick;

    // ****************************************************************
    // Decoding
    // ****************************************************************
    wire sel_c1   = (addr_i == OFS_CONTROL_ONE);
    wire sel_c2   = (addr_i == OFS_CONTROL_TWO);
    wire sel_baud = (addr_i == OFS_BAUD_CONFIG);
    wire sel_stat = (addr_i == OFS_SERIAL_STAT);
    wire sel_data = (addr_i == OFS_DATA_REG);
    wire sel_evt  = (addr_i == OFS_EVENT_STAT);
    wire sel_mask = (addr_i == OFS_EVENT_MASK);

    wire sys_on      = control_one_q[BIT_SYSTEM_ENABLE];
    wire is_master   = control_one_q[BIT_MASTER_SELECT];
    wire sel_out_en  = control_one_q[BIT_SEL_OUT_ENABLE];
    wire fault_en    = control_two_q[BIT_FAULT_ENABLE];
    wire miso_s      = pin_sync[0];
    wire ss_n_s      = pin_sync[1];

    wire stat_rd     = rd_i && sel_stat;
    wire data_rd     = rd_i && sel_data;
    wire data_wr     = wr_i && sel_data;
    wire c1_wr       = wr_i && sel_c1;

    // A data write counts only after an armed status read.
    wire tx_accept   = data_wr && arm_tx_q && tx_empty_flag_q;
    wire buf_full    = !tx_empty_flag_q;
    wire shift_idle  = (state_q == ST_IDLE);
    // The shifter takes the buffer when idle, or right at shift end.
    wire last_edge   = (state_q == ST_SHIFT) && half_tick
                       && (edge_cnt_q == LAST_EDGE);
    wire xfer_done   = sys_on && last_edge;
    wire load_idle   = sys_on && is_master && shift_idle && buf_full;
    wire load_chain  = xfer_done && buf_full;
    wire load_shift  = load_idle || load_chain;
    wire [7:0] rx_byte_w = {shift_q[6:0], sample_q};

    // The select pin acts as fault input in one configuration only.
    wire fault_mode  = is_master && fault_en && !sel_out_en;
    wire fault_hit   = sys_on && fault_mode && !ss_n_s;

    wire tx_room_evt = load_shift;
    wire [2:0] evt_set = {tx_room_evt, fault_hit, xfer_done};

    wire [7:0] stat_word = {rx_full_flag_q, 1'b0, tx_empty_flag_q,
                            mode_fault_flag_q, 4'h0};

    // Read selection; unmapped offsets read as zero.
    wire [7:0] rd_mux =
        sel_c1   ? control_one_q :
        sel_c2   ? control_two_q :
        sel_baud ? baud_config_q :
        sel_stat ? stat_word :
        sel_data ? rx_buf_q :
        sel_evt  ? {5'h00, event_stat_q} :
        sel_mask ? {5'h00, event_mask_q} : 8'h00;

    // ****************************************************************
    // Pin synchroniser and baud generator
    // ****************************************************************
    spi_sync2 u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .raw_i  ({ss_n_i, miso_i}),
        .sync_o (pin_sync)
    );

    spi_baud_gen u_baud (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .run_i       (state_q == ST_SHIFT),
        .pre_sel_i   (baud_config_q[PRE_SEL_HI:PRE_SEL_LO]),
        .div_sel_i   (baud_config_q[DIV_SEL_HI:DIV_SEL_LO]),
        .half_tick_o (half_tick)
    );

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Baud register has no interlock with the shifter; a change in
    // mid-transfer simply alters the remaining bit times.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            control_one_q <= RST_CONTROL_ONE;
            control_two_q <= RST_CONTROL_TWO;
            baud_config_q <= RST_BAUD_CONFIG;
            event_mask_q  <= RST_EVENTS;
        end else if (wr_i) begin
            if (sel_c1) control_one_q <= wdata_i;
            if (sel_c2) control_two_q <= wdata_i;
            if (sel_baud) baud_config_q <= wdata_i & 8'h77;
            if (sel_mask) event_mask_q <= wdata_i[2:0];
        end
    end

    // ****************************************************************
    // Shifter state machine
    // ****************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (load_idle) state_d = ST_SHIFT;
            end
            ST_SHIFT: begin
                if (last_edge && !buf_full) state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
        if (!sys_on) state_d = ST_IDLE;
    end

    // Bit clock idles low; sample on the rising half, shift on falling.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ST_IDLE;
            shift_q    <= 8'h00;
            edge_cnt_q <= 5'h00;
            sample_q   <= 1'b0;
            sclk_q     <= 1'b0;
        end else begin
            state_q <= state_d;
            if (!sys_on || load_shift) begin
                shift_q    <= sys_on ? tx_buf_q : 8'h00;
                edge_cnt_q <= 5'h00;
                sclk_q     <= 1'b0;
            end else if (state_q == ST_SHIFT && half_tick) begin
                edge_cnt_q <= edge_cnt_q + 5'h01;
                sclk_q     <= !sclk_q;
                if (!sclk_q) sample_q <= miso_s;
                else shift_q <= rx_byte_w;
            end
        end
    end

    // ****************************************************************
    // Buffers and flags
    // ****************************************************************
    // A receive overrun overwrites silently; there is no overrun flag.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_buf_q <= 8'h00;
            rx_buf_q <= 8'h00;
        end else if (!sys_on) begin
            tx_buf_q <= 8'h00;
            rx_buf_q <= 8'h00;
        end else begin
            if (tx_accept) tx_buf_q <= wdata_i;
            if (xfer_done) rx_buf_q <= rx_byte_w;
        end
    end

    // Sets win over the software clear sequences in the same cycle.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_empty_flag_q   <= 1'b1;
            rx_full_flag_q    <= 1'b0;
            mode_fault_flag_q <= 1'b0;
        end else begin
            if (!sys_on) tx_empty_flag_q <= 1'b1;
            else if (load_shift) tx_empty_flag_q <= 1'b1;
            else if (tx_accept) tx_empty_flag_q <= 1'b0;
            if (!sys_on) rx_full_flag_q <= 1'b0;
            else if (xfer_done) rx_full_flag_q <= 1'b1;
            else if (data_rd && arm_rx_q) rx_full_flag_q <= 1'b0;
            if (fault_hit) mode_fault_flag_q <= 1'b1;
            else if (c1_wr && arm_fault_q) mode_fault_flag_q <= 1'b0;
        end
    end

    // Arming bits remember a status read that saw the flag set.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            arm_rx_q    <= 1'b0;
            arm_tx_q    <= 1'b0;
            arm_fault_q <= 1'b0;
        end else begin
            if (stat_rd) arm_rx_q <= rx_full_flag_q;
            else if (data_rd || !rx_full_flag_q) arm_rx_q <= 1'b0;
            if (stat_rd) arm_tx_q <= tx_empty_flag_q;
            else if (data_wr || !tx_empty_flag_q) arm_tx_q <= 1'b0;
            if (stat_rd) arm_fault_q <= mode_fault_flag_q;
            else if (c1_wr || !mode_fault_flag_q) arm_fault_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Read port and interrupts
    // ****************************************************************
    // Events are sticky, write one to clear; a new event wins.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            event_stat_q   <= RST_EVENTS;
            rdata_q        <= 8'h00;
            tx_irq_q       <= 1'b0;
            rx_fault_irq_q <= 1'b0;
            event_irq_q    <= 1'b0;
        end else begin
            event_stat_q <= evt_set | (event_stat_q
                            & ~((wr_i && sel_evt) ? wdata_i[2:0] : 3'h0));
            rdata_q <= rd_i ? rd_mux : 8'h00;
            tx_irq_q <= tx_empty_flag_q
                        && control_one_q[BIT_TX_IRQ_ENABLE];
            rx_fault_irq_q <= (rx_full_flag_q || mode_fault_flag_q)
                        && control_one_q[BIT_RX_FAULT_IRQ_EN];
            event_irq_q <= |(event_stat_q & event_mask_q);
        end
    end

    assign rdata_o        = rdata_q;
    assign sclk_o         = sclk_q;
    assign mosi_o         = shift_q[7];
    assign tx_irq_o       = tx_irq_q;
    assign rx_fault_irq_o = rx_fault_irq_q;
    assign event_irq_o    = event_irq_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence seq_arm_rx;
        stat_rd && rx_full_flag_q;
    endsequence

    sequence seq_plain_data_rd;
        data_rd && !arm_rx_q && !xfer_done && sys_on;
    endsequence

    chk_rx_full_set: assert property (
        xfer_done |=> rx_full_flag_q)
        else $error("receive-full not set after transfer");

    chk_rx_arm_set: assert property (
        seq_arm_rx |=> arm_rx_q)
        else $error("status read did not arm receive clear");

    chk_rx_clear_seq: assert property (
        data_rd && arm_rx_q && !xfer_done && sys_on |=> !rx_full_flag_q)
        else $error("receive-full not cleared by sequence");

    chk_rx_no_clear: assert property (
        (rx_full_flag_q and seq_plain_data_rd) |=> rx_full_flag_q)
        else $error("receive-full cleared without status read");

    chk_tx_unarmed_wr: assert property (
        data_wr && !arm_tx_q && sys_on |=> $stable(tx_buf_q))
        else $error("unarmed data write was accepted");

    chk_tx_idle_load: assert property (
        tx_accept && shift_idle && is_master && sys_on
        ##1 (sys_on && is_master) |-> ##[0:1] tx_empty_flag_q)
        else $error("idle load did not set transmit-empty");

    chk_fault_gate: assert property (
        !fault_mode && !mode_fault_flag_q |=> !mode_fault_flag_q)
        else $error("mode fault set outside fault configuration");

    chk_fault_set: assert property (
        fault_hit |=> mode_fault_flag_q)
        else $error("mode fault not set");

    chk_status_zero: assert property (
        stat_rd |=> (rdata_q[6] == 1'b0) && (rdata_q[3:0] == 4'h0))
        else $error("unused status bits not zero");

    chk_disable_flags: assert property (
        !sys_on |=> tx_empty_flag_q && !rx_full_flag_q && shift_idle)
        else $error("disable did not reset flags");

    chk_tx_irq_out: assert property (
        tx_empty_flag_q && control_one_q[BIT_TX_IRQ_ENABLE] |=> tx_irq_o)
        else $error("transmit interrupt missing");

endmodule : spi_baud_top

/* File: spi_peer_model.sv */
// Serial slave model on the far side of the link.
// Assumes it is always selected: clock idles low, sampled on the rising
// edge, next bit shown after each falling edge, MSB first.
`timescale 1ns/100ps
module spi_peer_model #(
    parameter logic [7:0] REPLY = 8'h3C
) (
    // Link pins
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    // Last byte taken from the master
    output logic      [7:0] got_o
);
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    int         bits;

    // No select line marks a frame, so the first bit waits in advance.
    initial begin
        rx_q   = 8'h00;
        tx_q   = REPLY;
        bits   = 0;
        miso_o = REPLY[7];
        got_o  = 8'h00;
    end

    // Take the master's bit on the rising edge.
    always @(posedge sclk_i) begin
        rx_q = {rx_q[6:0], mosi_i};
        bits = bits + 1;
    end

    // Shift on the falling edge; the eighth one closes the frame.
    // A fall with no rise before it, as the clock leaves its unknown
    // start-up value at reset, must not move the waiting first bit.
    always @(negedge sclk_i) begin
        if (bits == 8) begin
            got_o = rx_q;
            tx_q  = REPLY;
            bits  = 0;
        end else if (bits != 0) begin
            tx_q = {tx_q[6:0], ~tx_q[0]};
        end
        miso_o = tx_q[7];
    end
endmodule : spi_peer_model

/* File: spi_sync2.sv */
// Two-stage synchroniser for the pins that enter from outside.
// Assumes the inputs are asynchronous levels; pulses shorter than a
// clock may be missed.
`timescale 1ns/100ps
module spi_sync2 (
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              nrst_i,
    // Raw and synchronised levels
    input  wire logic [spi_baud_pkg::SYNC_WIDTH-1:0] raw_i,
    output logic      [spi_baud_pkg::SYNC_WIDTH-1:0] sync_o
);
    import spi_baud_pkg::*;

    logic [SYNC_WIDTH-1:0] meta_q;

    // One pair of flops per bit; the first stage feeds only the second.
    for (genvar g = 0; g < SYNC_WIDTH; g++) begin : g_bit
        always_ff @(posedge clk_i or negedge nrst_i) begin
            if (!nrst_i) begin
                meta_q[g] <= 1'b1;
                sync_o[g] <= 1'b1;
            end else begin
                meta_q[g] <= raw_i[g];
                sync_o[g] <= meta_q[g];
            end
        end
    end

endmodule : spi_sync2

/* File: tb_top.sv */
// Self-checking bench for the serial unit top.
// Assumes the peer model answers every frame with the byte 8'h3C.
`timescale 1ns/100ps
module tb_top;
    import spi_baud_pkg::*;

    typedef struct packed {
        logic       wr;
        logic [2:0] adr;
        logic [7:0] val;
    } row_type;

    logic       clk_i, nrst_i, wr_i, rd_i, miso_i, ss_n_i, sclk_o, mosi_o;
    logic       tx_irq_o, rx_fault_irq_o, event_irq_o;
    logic [2:0] addr_i;
    logic [7:0] wdata_i, rdata_o, peer_byte, rv;
    logic [7:0] bauds [2] = '{8'h11, 8'h20};
    logic [7:0] sent  [2] = '{8'hA5, 8'h4B};
    int         mismatches, n_tests, n;
    row_type    rows [6] = '{'{1'b0, OFS_BAUD_CONFIG, 8'h00},
        '{1'b1, OFS_BAUD_CONFIG, 8'hFF}, '{1'b0, OFS_BAUD_CONFIG, 8'h77},
        '{1'b1, OFS_SERIAL_STAT, 8'hFF}, '{1'b0, OFS_SERIAL_STAT, 8'h20},
        '{1'b0, 3'h7, 8'h00}};

    spi_baud_top uut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .miso_i(miso_i), .ss_n_i(ss_n_i), .sclk_o(sclk_o),
        .mosi_o(mosi_o), .tx_irq_o(tx_irq_o),
        .rx_fault_irq_o(rx_fault_irq_o), .event_irq_o(event_irq_o));
    spi_peer_model peer (.sclk_i(sclk_o), .mosi_i(mosi_o),
        .miso_o(miso_i), .got_o(peer_byte));

    // ****************************************************************
    // Bus and checking tasks
    // ****************************************************************
    task automatic final_report;
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [7:0] e, s);
        n_tests++;
        if (s !== e) begin
            $display("Error %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask : chk
    task automatic idle(input int c);
        repeat (c) @(posedge clk_i);
        #1;
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    task automatic rc(input string nm, input logic [2:0] a, logic [7:0] e);
        rd(a, rv);
        chk(nm, e, rv);
    endtask : rc
    // Polls status; the read that sees the flag also arms its clearing.
    task automatic wait_rx;
        rv = 8'h00;
        for (int i = 0; i < 100 && rv[7] !== 1'b1; i++) rd(3'h3, rv);
        chk("rx_wait", 8'hA0, rv);
        if (rv[7] !== 1'b1) final_report();
    endtask : wait_rx
    // Rising edge to rising edge of the bit clock, in bus cycles.
    task automatic period(output int c);
        c = 0;
        for (int i = 0; i < 600 && sclk_o !== 1'b1; i++) idle(1);
        for (; c < 600 && sclk_o !== 1'b0; c++) idle(1);
        for (; c < 600 && sclk_o !== 1'b1; c++) idle(1);
        if (c >= 600) begin
            mismatches++;
            final_report();
        end
    endtask : period

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        {nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        ss_n_i = 1'b1;
        mismatches = 0;
        n_tests = 0;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        // Must precede every status read, which would arm the write.
        wr(OFS_CONTROL_ONE, 8'h50);
        wr(OFS_DATA_REG, 8'h55);
        n = 0;
        for (int i = 0; i < 20; i++) begin
            idle(1);
            if (sclk_o !== 1'b0) n++;
        end
        chk("sclk_idle", 8'h00, n[7:0]);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].adr, rows[i].val);
            end else begin
                rc("row_read", rows[i].adr, rows[i].val);
            end
        end
        wr(OFS_CONTROL_ONE, 8'hF0);
        wr(OFS_EVENT_MASK, 8'h01);
        idle(2);
        chk("tx_irq", 8'h01, {7'h00, tx_irq_o});
        for (int i = 0; i < 2; i++) begin
            wr(OFS_BAUD_CONFIG, bauds[i]);
            rc("stat_arm", OFS_SERIAL_STAT, 8'h20);
            wr(OFS_DATA_REG, sent[i]);
            idle(1);
            rc("stat_load", OFS_SERIAL_STAT, 8'h20);
            period(n);
            chk("bit_period", 8'((bauds[i][6:4] + 1) << (bauds[i][2:0] + 1)),
                n[7:0]);
            wait_rx();
            chk("rx_irq", 8'h01, {7'h00, rx_fault_irq_o});
            chk("evt_irq", 8'h01, {7'h00, event_irq_o});
            rc("rx_data", OFS_DATA_REG, 8'h3C);
            chk("peer_byte", sent[i], peer_byte);
            rc("rx_clear", OFS_SERIAL_STAT, 8'h20);
            wr(OFS_EVENT_STAT, 8'h07);
            idle(2);
            chk("evt_clear", 8'h00, {7'h00, event_irq_o});
        end
        // Second byte queued behind the first must chain on its own.
        rc("stat_arm", OFS_SERIAL_STAT, 8'h20);
        wr(OFS_DATA_REG, 8'h81);
        idle(1);
        rc("stat_arm", OFS_SERIAL_STAT, 8'h20);
        wr(OFS_DATA_REG, 8'h7E);
        rc("stat_full", OFS_SERIAL_STAT, 8'h00);
        chk("tx_irq_off", 8'h00, {7'h00, tx_irq_o});
        wait_rx();
        rc("rx_data", OFS_DATA_REG, 8'h3C);
        chk("peer_byte", 8'h81, peer_byte);
        // Data read before any status read must leave receive-full set.
        idle(60);
        rc("rx_unarmed", OFS_DATA_REG, 8'h3C);
        wait_rx();
        chk("peer_byte", 8'h7E, peer_byte);
        wr(OFS_CONTROL_ONE, 8'h00);
        rc("stat_off", OFS_SERIAL_STAT, 8'h20);
        wr(OFS_CONTROL_TWO, 8'h10);
        wr(OFS_CONTROL_ONE, 8'hD2);
        @(posedge clk_i);
        ss_n_i <= 1'b0;
        idle(4);
        rc("no_fault", OFS_SERIAL_STAT, 8'h20);
        wr(OFS_CONTROL_ONE, 8'hD0);
        idle(4);
        @(posedge clk_i);
        ss_n_i <= 1'b1;
        idle(4);
        wr(OFS_CONTROL_ONE, 8'hD0);
        rc("fault_held", OFS_SERIAL_STAT, 8'h30);
        chk("fault_irq", 8'h01, {7'h00, rx_fault_irq_o});
        wr(OFS_CONTROL_ONE, 8'hD0);
        rc("fault_clr", OFS_SERIAL_STAT, 8'h20);
        final_report();
    end
endmodule : tb_top
